// [test/etc_mem_model.sv]
// Memory partner on the transfer controller's bus
`timescale 1ns/10ps
module etc_mem_model
  import etc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Memory bus slave side
  input wire etc_mem_s mem,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] m [logic [31:0]];
  int gap = 0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
  end
  // Random wait of zero to three cycles; data toggles outside the ack
  always @(posedge aclk) begin
    if (!aresetn || mem_ack || !mem.req) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      gap = $urandom_range(3);
    end else if (gap > 0) begin
      gap--;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      if (mem.we)
        m[mem.addr] = mem.wdata;
      mem_rdata <= m.exists(mem.addr) ? m[mem.addr] : 32'h0;
    end
  end
endmodule

// [test/etc_top_asserts.sv]
// Port checks for the event transfer controller
`timescale 1ns/10ps
module etc_top_asserts
  import etc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register read answer
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // Requests and memory bus
  input wire logic [ETC_NCH-1:0] req_i,
  input wire logic [ETC_NCH-1:0] req_ack,
  input wire etc_mem_s mem,
  input wire logic mem_ack,
  // Events
  input wire logic [ETC_NCH-1:0] cpu_irq,
  input wire logic elc_req
);
  logic wr_done;
  assign wr_done = mem.req && mem.we && mem_ack;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ack_onehot_a: assert property ($onehot0(req_ack))
    else $error("Several channels acknowledged");
  ack_source_a: assert property (
    req_ack != 8'h0 |-> (req_ack & $past(req_i)) == req_ack)
    else $error("Acknowledge without request");
  chain_busy_a: assert property (
    req_ack != 8'h0 |=> (req_ack == 8'h0) [*8])
    else $error("Request taken while busy");
  mem_hold_a: assert property (
    mem.req && !mem_ack |=> mem.req && $stable(mem.addr)
      && $stable(mem.size))
    else $error("Memory request changed before ack");
  size_legal_a: assert property (mem.req |-> mem.size != 2'h3)
    else $error("Illegal item size");
  elc_cause_a: assert property (
    elc_req |-> $past(wr_done) || $past(wr_done, 2))
    else $error("Event link without item write");
  elc_pulse_a: assert property (elc_req |=> !elc_req)
    else $error("Event link longer than one cycle");
  irq_pulse_a: assert property (
    cpu_irq != 8'h0 |-> $onehot(cpu_irq) ##1 cpu_irq == 8'h0)
    else $error("Bad cpu interrupt pulse");
  rdata_hold_a: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("Read answer dropped");
endmodule
bind etc_top etc_top_asserts u_etc_top_asserts (.*);

// [test/testbench.sv]
// Self-checking testbench for the event transfer controller
`timescale 1ns/10ps
module testbench
  import etc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic [ETC_NCH-1:0] req_i = '0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic mem_ack, elc_req, irq, hit;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata, mem_rdata, dba, k;
  logic [31:0] v [3];
  logic [ETC_NCH-1:0] req_ack, cpu_irq;
  logic [2:0] ch;
  etc_mem_s mem;
  logic [63:0] wq[$], rq[$], iq[$], bq[$];
  int miscompares = 0, total_checks = 0, elc_n = 0, wb_n = 0, e0;

  initial forever #4 aclk = ~aclk;

  etc_top u_etc_top (.*, .s_wstrb(4'hf));
  etc_mem_model u_etc_mem_model (.*);

  task automatic finish_test;
    $display("Checks %0d, errors %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic tmo(input int i);
    if (i >= 400) begin
      miscompares++;
      finish_test;
    end
  endtask

  task automatic put(input logic [31:0] a, input logic [31:0] d);
    u_etc_mem_model.m[a] = d;
  endtask

  task automatic dsc(input logic [31:0] c, s, d, n);
    put(dba, c);
    put(dba + 4, s);
    put(dba + 8, d);
    put(dba + 12, n);
  endtask

  function automatic logic [31:0] msk(input logic [1:0] z);
    return z == 2'h0 ? 32'hff : z == 2'h1 ? 32'hffff : 32'hffff_ffff;
  endfunction

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int i = 0;
    bq.push_back({62'h0, r});
    s_awaddr <= {27'h0, a};
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid && i < 400);
    s_bready <= 1'b0;
    tmo(i);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int i = 0;
    rq.push_back({30'h0, r, d});
    s_araddr <= {27'h0, a};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid && i < 400);
    s_rready <= 1'b0;
    tmo(i);
    @(posedge aclk);
  endtask

  task automatic fire;
    int i = 0;
    iq.push_back({56'h0, 8'h1 << ch});
    req_i[ch] <= 1'b1;
    for (i = 0; i < 400 && !req_ack[ch]; i++) @(posedge aclk);
    req_i[ch] <= 1'b0;
    tmo(i);
    for (i = 0; i < 400 && !cpu_irq[ch]; i++) @(posedge aclk);
    tmo(i);
    @(posedge aclk);
  endtask

  // Results as they appear, against the oldest note
  always @(posedge aclk) begin
    if (mem.req && mem.we && mem_ack && mem.addr[15:12] == 4'h3)
      chk({mem.addr, mem.wdata & msk(mem.size)}, wq.pop_front());
    if (cpu_irq != 8'h0)
      chk({56'h0, cpu_irq}, iq.pop_front());
    if (elc_req)
      elc_n++;
    if (mem.req && mem.we && mem_ack && mem.addr[31:8] == 24'h1)
      wb_n++;
    if (s_rvalid && s_rready)
      chk({30'h0, s_rresp, s_rdata}, rq.pop_front());
    if (s_bvalid && s_bready)
      chk({62'h0, s_bresp}, bq.pop_front());
  end

  initial begin
    void'($urandom(79));
    ch = 3'($urandom_range(6));
    dba = 32'h100 + {25'h0, ch, 4'h0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ETC_OFF_CTRL, {29'h0, ETC_CTRL_RST}, ETC_RESP_OKAY);
    rd(ETC_OFF_BASE, ETC_BASE_RST, ETC_RESP_OKAY);
    rd(ETC_OFF_STAT, 32'h0, ETC_RESP_OKAY);
    rd(5'h14, 32'h0, ETC_RESP_SLVERR);
    wr(5'h14, 32'h5, ETC_RESP_SLVERR);
    wr(ETC_OFF_BASE, 32'h100, ETC_RESP_OKAY);
    wr(ETC_OFF_IMASK, 32'h7, ETC_RESP_OKAY);
    // Normal mode in byte, word and longword
    e0 = elc_n;
    for (k = 0; k < 3; k++) begin
      v[0] = $urandom;
      put(32'h2000, v[0]);
      dsc(32'h230 | (k << 2), 32'h2000, 32'h3000 + (k << 4), 32'h1_0001);
      wq.push_back({32'h3000 + (k << 4), v[0] & msk(k[1:0])});
      fire;
    end
    chk(64'(wq.size()), 64'h0);
    chk(64'(elc_n - e0), 64'h3);
    chk({63'h0, irq}, 64'h1);
    rd(ETC_OFF_ISTAT, 32'h7, ETC_RESP_OKAY);
    wr(ETC_OFF_IMASK, 32'h0, ETC_RESP_OKAY);
    chk({63'h0, irq}, 64'h0);
    wr(ETC_OFF_ISTAT, 32'h7, ETC_RESP_OKAY);
    rd(ETC_OFF_ISTAT, 32'h0, ETC_RESP_OKAY);
    wr(ETC_OFF_IMASK, 32'h7, ETC_RESP_OKAY);
    // Repeat mode, source wraps after two items
    e0 = elc_n;
    for (k = 0; k < 3; k++) v[k] = $urandom;
    put(32'h2100, v[0]);
    put(32'h2104, v[1]);
    dsc(32'h239, 32'h2100, 32'h3100, 32'h5_0202);
    for (k = 0; k < 3; k++) begin
      wq.push_back({32'h3100 + (k << 2), v[k[0]]});
      fire;
    end
    chk(64'(wq.size()), 64'h0);
    chk(64'(elc_n - e0), 64'h3);
    // Block of three longwords, one event link
    e0 = elc_n;
    dsc(32'h23a, 32'h2200, 32'h3200, 32'h1_0003);
    for (k = 0; k < 3; k++) begin
      put(32'h2200 + (k << 2), v[k]);
      wq.push_back({32'h3200 + (k << 2), v[k]});
    end
    fire;
    chk(64'(wq.size()), 64'h0);
    chk(64'(elc_n - e0), 64'h1);
    // Chain at count zero, then chain always, into a third description
    dsc(32'h2b8, 32'h2200, 32'h3300, 32'h1_0001);
    dba = dba + 16;
    dsc(32'h3b8, 32'h2204, 32'h3304, 32'h2_0001);
    dba = dba + 16;
    dsc(32'h238, 32'h2208, 32'h3308, 32'h1_0001);
    dba = dba - 32;
    for (k = 0; k < 3; k++) wq.push_back({32'h3300 + (k << 2), v[k]});
    fire;
    chk(64'(wq.size()), 64'h0);
    // Short then full addressing
    put(32'hff80_2400, v[2]);
    put(32'h8080_2400, v[1]);
    put(32'h8080_2404, v[0]);
    dsc(32'h238, 32'h0080_2400, 32'h3400, 32'h1_0001);
    wq.push_back({32'h3400, v[2]});
    fire;
    chk(64'(wq.size()), 64'h0);
    wr(ETC_OFF_CTRL, 32'h2, ETC_RESP_OKAY);
    dsc(32'h238, 32'h8080_2400, 32'h3500, 32'h1_0001);
    wq.push_back({32'h3500, v[1]});
    fire;
    chk(64'(wq.size()), 64'h0);
    // Module stop refuses requests until released
    wr(ETC_OFF_CTRL, 32'h3, ETC_RESP_OKAY);
    hit = 1'b0;
    req_i[ch] <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      hit = hit | req_ack[ch];
    end
    req_i[ch] <= 1'b0;
    chk({63'h0, hit}, 64'h0);
    wr(ETC_OFF_CTRL, 32'h2, ETC_RESP_OKAY);
    wq.push_back({32'h3504, v[0]});
    fire;
    chk(64'(wq.size()), 64'h0);
    // Read skip keeps the cached description, fixed source skips write-back
    wr(ETC_OFF_CTRL, 32'h6, ETC_RESP_OKAY);
    dsc(32'h228, 32'h2200, 32'h3600, 32'h2_0001);
    e0 = wb_n;
    wq.push_back({32'h3600, v[0]});
    fire;
    dsc(32'h228, 32'h2204, 32'h3700, 32'h2_0001);
    wq.push_back({32'h3604, v[0]});
    fire;
    chk(64'(wq.size()), 64'h0);
    chk(64'(wb_n - e0), 64'h4);
    finish_test;
  end
endmodule

// [verilog/etc_pkg.sv]
// Package of constants, types and states for the event transfer controller
package etc_pkg;
  localparam int ETC_NCH = 8;
  localparam logic [4:0] ETC_OFF_CTRL = 5'h00;
  localparam logic [4:0] ETC_OFF_BASE = 5'h04;
  localparam logic [4:0] ETC_OFF_STAT = 5'h08;
  localparam logic [4:0] ETC_OFF_ISTAT = 5'h0c;
  localparam logic [4:0] ETC_OFF_IMASK = 5'h10;
  localparam int ETC_CTRL_STOP = 0;
  localparam int ETC_CTRL_FULL = 1;
  localparam int ETC_CTRL_RSKIP = 2;
  localparam logic [2:0] ETC_CTRL_RST = 3'h0;
  localparam logic [31:0] ETC_BASE_RST = 32'h0000_0000;
  localparam int ETC_IRQ_ITEM = 0;
  localparam int ETC_IRQ_TOTAL = 1;
  localparam int ETC_IRQ_REQ = 2;
  localparam int ETC_NIRQ = 3;
  localparam logic [31:0] ETC_DESC_BYTES = 32'h0000_0010;
  localparam logic [1:0] ETC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ETC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] ETC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] ETC_MODE_REPEAT = 2'h1;
  localparam logic [1:0] ETC_MODE_BLOCK = 2'h2;
  localparam logic [1:0] ETC_SZ_LONG = 2'h2;
  localparam int ETC_SHORT_MSB = 23;

  // Control word of a transfer description (word 0, low bits)
  typedef struct packed {
    logic [21:0] unused;
    logic irq_each;
    logic chain_always;
    logic chain_en;
    logic rpt_dst;
    logic dst_inc;
    logic src_inc;
    logic [1:0] size;
    logic [1:0] mode;
  } etc_ctl_s;

  // Count word of a transfer description (word 3)
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] remain;
    logic [7:0] rsize;
  } etc_cnt_s;

  // Master side of the memory bus
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } etc_mem_s;

  typedef enum logic [2:0] {
    ETC_IDLE = 3'h0,
    ETC_FETCH = 3'h1,
    ETC_READ = 3'h3,
    ETC_WRITE = 3'h2,
    ETC_WBACK = 3'h6,
    ETC_DONE = 3'h7
  } etc_state_e;
endpackage

// [verilog/etc_top.sv]
// Event transfer controller: request driven memory mover with register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module etc_top
  import etc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register slave
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Transfer requests from the interrupt controller
  input wire logic [ETC_NCH-1:0] req_i,
  output logic [ETC_NCH-1:0] req_ack,
  // Memory bus master
  output etc_mem_s mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Event and interrupt outputs
  output logic [ETC_NCH-1:0] cpu_irq,
  output logic elc_req,
  output logic irq
);

  function automatic logic [31:0] step_of(input logic [1:0] sz);
    step_of = 32'h1 << sz;
  endfunction

  function automatic logic [31:0] map_addr(input logic [31:0] a,
                                           input logic full);
    if (full) begin
      map_addr = a;
    end else begin
      map_addr = {{8{a[ETC_SHORT_MSB]}}, a[ETC_SHORT_MSB:0]};
    end
  endfunction

  function automatic logic [31:0] trim(input logic [31:0] d,
                                       input logic [1:0] sz);
    case (sz)
      2'h0: trim = {24'h0, d[7:0]};
      2'h1: trim = {16'h0, d[15:0]};
      default: trim = d;
    endcase
  endfunction

  function automatic logic [8:0] blk_len(input logic [7:0] r);
    blk_len = {r == 8'h0, r};
  endfunction

  // Register state
  logic [2:0] ctrl_r;
  logic [31:0] base_r;
  logic [ETC_NIRQ-1:0] istat_r, istat_nxt, imask_r, iset;
  logic aw_got_r, w_got_r;
  logic [4:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // Engine state
  etc_state_e state_r;
  logic [2:0] ch_r, last_ch_r;
  logic [31:0] dptr_r, data_r;
  logic [31:0] desc_r [0:3];
  logic [1:0] widx_r;
  logic [8:0] blk_left_r;
  logic skip_ok_r, chained_r;

  // Register decode
  wire wr_go = aw_got_r && w_got_r && !s_bvalid;
  wire wr_ctrl = wr_go && awaddr_r == ETC_OFF_CTRL && wstrb_r[0];
  wire wr_base = wr_go && awaddr_r == ETC_OFF_BASE;
  wire wr_istat = wr_go && awaddr_r == ETC_OFF_ISTAT && wstrb_r[0];
  wire wr_imask = wr_go && awaddr_r == ETC_OFF_IMASK && wstrb_r[0];
  wire wr_hit = awaddr_r == ETC_OFF_CTRL || awaddr_r == ETC_OFF_BASE ||
                awaddr_r == ETC_OFF_ISTAT || awaddr_r == ETC_OFF_IMASK;
  wire [4:0] ra = s_araddr[4:0];
  wire rd_hit = s_araddr[31:5] == 27'h0 && ra[1:0] == 2'h0 && ra <= 5'h10;
  wire rd_go = s_arvalid && !s_rvalid;
  wire [31:0] stat_word = {24'h0, chained_r, ch_r, 1'b0, state_r};
  wire [31:0] rd_word =
      ra == ETC_OFF_CTRL ? {29'h0, ctrl_r} :
      ra == ETC_OFF_BASE ? base_r :
      ra == ETC_OFF_STAT ? stat_word :
      ra == ETC_OFF_ISTAT ? {29'h0, istat_r} :
      ra == ETC_OFF_IMASK ? {29'h0, imask_r} : 32'h0;

  // Description fields
  etc_ctl_s ctl;
  etc_cnt_s cnt;
  assign ctl = etc_ctl_s'(desc_r[0]);
  assign cnt = etc_cnt_s'(desc_r[3]);
  etc_cnt_s rd_cnt;
  assign rd_cnt = etc_cnt_s'(mem_rdata);
  wire stop = ctrl_r[ETC_CTRL_STOP];
  wire full = ctrl_r[ETC_CTRL_FULL];
  wire [31:0] step = step_of(ctl.size);
  wire [8:0] rsize_full = blk_len(cnt.rsize);
  wire [31:0] span = 32'(rsize_full) << ctl.size;
  wire is_rpt = ctl.mode == ETC_MODE_REPEAT;
  wire is_blk = ctl.mode == ETC_MODE_BLOCK;

  // Request selection, lowest channel first
  logic [2:0] sel_ch;
  always_comb begin
    sel_ch = 3'h0;
    for (int i = ETC_NCH - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        sel_ch = 3'(i);
      end
    end
  end
  wire take = state_r == ETC_IDLE && |req_i && !stop;
  wire skip_rd = ctrl_r[ETC_CTRL_RSKIP] && skip_ok_r &&
                 sel_ch == last_ch_r;

  // Item and block bookkeeping at the end of a write
  wire bus_done = mem.req && mem_ack;
  wire wr_end = state_r == ETC_WRITE && bus_done;
  wire blk_end = blk_left_r == 9'h1;
  wire rpt_wrap = is_rpt && cnt.remain == 8'h1;
  wire reload = rpt_wrap || (is_blk && blk_end);
  wire cnt_step = !is_rpt && (!is_blk || blk_end);
  wire total_hit = cnt_step && cnt.count == 16'h1;
  wire [31:0] src_inc = ctl.src_inc ? desc_r[1] + step : desc_r[1];
  wire [31:0] dst_inc = ctl.dst_inc ? desc_r[2] + step : desc_r[2];
  wire [31:0] src_new = reload && !ctl.rpt_dst ? src_inc - span : src_inc;
  wire [31:0] dst_new = reload && ctl.rpt_dst ? dst_inc - span : dst_inc;
  wire [7:0] remain_new = !is_rpt ? cnt.remain :
                          rpt_wrap ? cnt.rsize : cnt.remain - 8'h1;
  wire [15:0] count_new = cnt_step ? cnt.count - 16'h1 : cnt.count;

  // Write-back and chain decisions
  wire wb_need = widx_r == 2'h3 || (widx_r == 2'h1 && ctl.src_inc) ||
                 (widx_r == 2'h2 && ctl.dst_inc);
  wire chain_go = ctl.chain_en &&
                  (ctl.chain_always || cnt.count == 16'h0);

  // Memory request for the present state
  logic [31:0] bus_addr;
  always_comb begin
    bus_addr = 32'h0;
    case (state_r)
      ETC_FETCH: bus_addr = dptr_r + {28'h0, widx_r, 2'h0};
      ETC_READ: bus_addr = map_addr(desc_r[1], full);
      ETC_WRITE: bus_addr = map_addr(desc_r[2], full);
      ETC_WBACK: bus_addr = dptr_r + {28'h0, widx_r, 2'h0};
      default: bus_addr = 32'h0;
    endcase
  end
  wire bus_state = state_r == ETC_FETCH || state_r == ETC_READ ||
                   state_r == ETC_WRITE || (state_r == ETC_WBACK && wb_need);
  wire launch = bus_state && !mem.req;
  wire word_acc = state_r == ETC_FETCH || state_r == ETC_WBACK;

  // Interrupt status, set wins over clear
  assign iset[ETC_IRQ_ITEM] = wr_end && ctl.irq_each;
  assign iset[ETC_IRQ_TOTAL] = wr_end && total_hit;
  assign iset[ETC_IRQ_REQ] = state_r == ETC_DONE && !chain_go;
  assign istat_nxt = (istat_r & ~(wr_istat ? wdata_r[ETC_NIRQ-1:0] :
                      {ETC_NIRQ{1'b0}})) | iset;

  // Next handshake state, so the ready outputs come from flip-flops
  wire aw_got_nxt = !wr_go && (aw_got_r || (s_awvalid && s_awready));
  wire w_got_nxt = !wr_go && (w_got_r || (s_wvalid && s_wready));
  wire bvalid_nxt = wr_go || (s_bvalid && !s_bready);
  wire rvalid_nxt = rd_go || (s_rvalid && !s_rready);

  // AXI4-Lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 5'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= ETC_RESP_OKAY;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= ETC_RESP_OKAY;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_arready <= 1'b1;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_awaddr[31:5] == 27'h0 ? s_awaddr[4:0] : 5'h1f;
      end
      if (s_wvalid && s_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit ? ETC_RESP_OKAY : ETC_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_hit ? rd_word : 32'h0;
        s_rresp <= rd_hit ? ETC_RESP_OKAY : ETC_RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
      s_awready <= !aw_got_nxt && !bvalid_nxt;
      s_wready <= !w_got_nxt && !bvalid_nxt;
      s_arready <= !rvalid_nxt;
    end
  end

  // Software registers and interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= ETC_CTRL_RST;
      base_r <= ETC_BASE_RST;
      istat_r <= '0;
      imask_r <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_r[2:0];
      end
      if (wr_base) begin
        base_r <= wdata_r;
      end
      if (wr_imask) begin
        imask_r <= wdata_r[ETC_NIRQ-1:0];
      end
      istat_r <= istat_nxt;
      irq <= |(istat_nxt & imask_r);
    end
  end

  // Memory master
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem <= '0;
    end else if (bus_done) begin
      mem.req <= 1'b0;
    end else if (launch) begin
      mem.req <= 1'b1;
      mem.we <= state_r == ETC_WRITE || state_r == ETC_WBACK;
      mem.size <= word_acc ? ETC_SZ_LONG : ctl.size;
      mem.addr <= bus_addr;
      mem.wdata <= state_r == ETC_WBACK ? desc_r[widx_r] : data_r;
    end
  end

  // Transfer engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ETC_IDLE;
      ch_r <= 3'h0;
      last_ch_r <= 3'h0;
      dptr_r <= 32'h0;
      data_r <= 32'h0;
      widx_r <= 2'h0;
      blk_left_r <= 9'h1;
      skip_ok_r <= 1'b0;
      chained_r <= 1'b0;
      req_ack <= '0;
      cpu_irq <= '0;
      elc_req <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        desc_r[i] <= 32'h0;
      end
    end else begin
      req_ack <= '0;
      cpu_irq <= '0;
      elc_req <= 1'b0;
      case (state_r)
        ETC_IDLE: begin
          if (take) begin
            ch_r <= sel_ch;
            req_ack[sel_ch] <= 1'b1;
            dptr_r <= base_r + {25'h0, sel_ch, 4'h0};
            chained_r <= 1'b0;
            widx_r <= 2'h0;
            blk_left_r <= is_blk ? rsize_full : 9'h1;
            state_r <= skip_rd ? ETC_READ : ETC_FETCH;
          end
        end
        ETC_FETCH: begin
          if (bus_done) begin
            desc_r[widx_r] <= mem_rdata;
            widx_r <= widx_r + 2'h1;
            if (widx_r == 2'h3) begin
              blk_left_r <= ctl.mode == ETC_MODE_BLOCK ?
                            blk_len(rd_cnt.rsize) :
                            9'h1;
              state_r <= ETC_READ;
            end
          end
        end
        ETC_READ: begin
          if (bus_done) begin
            data_r <= trim(mem_rdata, ctl.size);
            state_r <= ETC_WRITE;
          end
        end
        ETC_WRITE: begin
          if (bus_done) begin
            desc_r[1] <= src_new;
            desc_r[2] <= dst_new;
            desc_r[3] <= {count_new, remain_new, cnt.rsize};
            blk_left_r <= blk_left_r - 9'h1;
            elc_req <= !is_blk || blk_end;
            if (is_blk && !blk_end) begin
              state_r <= ETC_READ;
            end else begin
              widx_r <= 2'h1;
              state_r <= ETC_WBACK;
            end
          end
        end
        ETC_WBACK: begin
          if (!wb_need) begin
            widx_r <= widx_r + 2'h1;
          end else if (bus_done) begin
            widx_r <= widx_r + 2'h1;
            if (widx_r == 2'h3) begin
              state_r <= ETC_DONE;
            end
          end
        end
        ETC_DONE: begin
          if (chain_go) begin
            dptr_r <= dptr_r + ETC_DESC_BYTES;
            chained_r <= 1'b1;
            widx_r <= 2'h0;
            state_r <= ETC_FETCH;
          end else begin
            cpu_irq[ch_r] <= ctl.irq_each ||
                             cnt.count == 16'h0;
            last_ch_r <= ch_r;
            skip_ok_r <= !chained_r;
            state_r <= ETC_IDLE;
          end
        end
        default: state_r <= ETC_IDLE;
      endcase
      // Writes to CTRL or BASE invalidate the cached description, even in DONE
      if (wr_base || wr_ctrl) begin
        skip_ok_r <= 1'b0;
      end
    end
  end

endmodule
